// file: inc/fhpb_defs.vh
// constants of the furnace hot-mode purge bypass block
// assumes a 250 MHz aclk; long counts are overridable parameters at the top
`ifndef FHPB_DEFS_VH
`define FHPB_DEFS_VH

// register byte offsets
`define FHPB_CTRL_OFS       8'h00
`define FHPB_STAT_OFS       8'h04
`define FHPB_IRQ_STAT_OFS   8'h08
`define FHPB_IRQ_MASK_OFS   8'h0c
`define FHPB_SEQ_OFS        8'h10

// control field positions
`define FHPB_CTRL_POL_LO    0
`define FHPB_CTRL_POL_HI    1
`define FHPB_CTRL_LINKED    2
`define FHPB_CTRL_USE1      3
`define FHPB_CTRL_USE2      4
`define FHPB_CTRL_RESTART   5
`define FHPB_CTRL_RESET     32'h0000_0018
`define FHPB_CTRL_WR_MASK   32'h0000_003f

// hot-mode policy values
`define FHPB_POL_DISABLE    2'h0
`define FHPB_POL_FIRST      2'h1
`define FHPB_POL_EVERY      2'h2
`define FHPB_POL_NORMAL     2'h3

// interrupt events
`define FHPB_EV_ENTER       0
`define FHPB_EV_EXIT        1
`define FHPB_EV_LOCKOUT     2
`define FHPB_EV_SKIP        3

// timing
`define FHPB_CLK_MHZ        250
`define FHPB_MISMATCH_MIN   10
`define FHPB_DIAG_PERIOD_MIN 60
`define FHPB_DIAG_PULSE_MS  1000
`define FHPB_DIAG_WAIT_MS   2000
// 40-bit factor keeps the long counts from wrapping at 32 bits
`define FHPB_CYC_PER_MS     (40'd1000 * `FHPB_CLK_MHZ)
`define FHPB_MISMATCH_CYC   (`FHPB_MISMATCH_MIN * 60 * 1000 * `FHPB_CYC_PER_MS)
`define FHPB_DIAG_PERIOD_CYC (`FHPB_DIAG_PERIOD_MIN * 60 * 1000 * `FHPB_CYC_PER_MS)
`define FHPB_DIAG_PULSE_CYC (`FHPB_DIAG_PULSE_MS * `FHPB_CYC_PER_MS)
`define FHPB_DIAG_WAIT_CYC  (`FHPB_DIAG_WAIT_MS * `FHPB_CYC_PER_MS)

`endif

// file: logic/fhpb_sync.v
// two-flop synchroniser for the contact inputs
// assumes asynchronous pin levels, one aclk domain
`timescale 1ns/1ps
`default_nettype none
module fhpb_sync (
    // clock
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       ce,
    // data
    input  wire [1:0] pin_in,
    output reg  [1:0] sync_out
);
    reg [1:0] meta;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta     <= 2'h0;
            sync_out <= 2'h0;
        end else if (ce) begin
            meta     <= pin_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

// file: logic/fhpb_top.v
// hot-furnace purge bypass sequencing with axi4-lite registers
// assumes contacts from two temperature controllers and a sequencer
// that reports decision points and obeys the skip/ignite answers
`timescale 1ns/1ps
`default_nettype none
`include "fhpb_defs.vh"
module fhpb_top #(
    parameter [39:0] MISMATCH_CYC = `FHPB_MISMATCH_CYC,
    parameter [39:0] DIAG_PERIOD_CYC = `FHPB_DIAG_PERIOD_CYC,
    parameter [39:0] DIAG_PULSE_CYC = `FHPB_DIAG_PULSE_CYC,
    parameter [39:0] DIAG_WAIT_CYC = `FHPB_DIAG_WAIT_CYC
) (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ce,
    // axi4-lite write
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // temperature controller contacts and diagnosis
    input  wire [1:0]  hot_contact,
    output reg  [1:0]  diag_out,
    // burner sequence decision points
    input  wire        air_ok_point,
    input  wire        heat_demand_point,
    input  wire        in_purge_phase,
    input  wire        start_req,
    input  wire        flame_sensed,
    output reg         skip_purge,
    output reg         run_purge,
    output wire        ignite_ok,
    output reg         lockout,
    output wire        hot_mode_out,
    output wire        irq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg  [31:0] ctrl;
    wire [3:0]  irq_stat;
    reg  [3:0]  irq_mask;
    reg  [15:0] seq_count;
    reg         aw_held;
    reg  [7:0]  aw_addr;
    reg         w_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         hot;
    reg         first_done;
    reg  [39:0] mis_cnt;
    reg  [39:0] diag_cnt;
    reg  [1:0]  diag_state;
    reg  [3:0]  irq_event;

    wire [1:0]  contact_s;
    wire [1:0]  policy = ctrl[`FHPB_CTRL_POL_HI:`FHPB_CTRL_POL_LO];
    wire [1:0]  use_mask = {ctrl[`FHPB_CTRL_USE2], ctrl[`FHPB_CTRL_USE1]};
    wire        linked = ctrl[`FHPB_CTRL_LINKED];

    localparam [1:0] DG_IDLE  = 2'h0;
    localparam [1:0] DG_PULSE = 2'h1;
    localparam [1:0] DG_WAIT  = 2'h2;

    fhpb_sync u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .ce       (ce),
        .pin_in   (hot_contact),
        .sync_out (contact_s)
    );

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire do_read  = s_axi_arvalid && !s_axi_rvalid;
    // no handshake while frozen, else a taken request would be lost
    assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = ce && !w_held && !s_axi_bvalid;
    assign s_axi_arready = ce && !s_axi_rvalid;

    wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    // each field in its own bits, so that contacts and mode never alias
    wire [31:0] stat_word;
    assign stat_word[1:0]  = contact_s;
    assign stat_word[3:2]  = diag_out;
    assign stat_word[4]    = lockout;
    assign stat_word[5]    = first_done;
    assign stat_word[6]    = hot;
    assign stat_word[31:7] = 25'h0;
    wire        rd_irq = ce && do_read && s_axi_araddr == `FHPB_IRQ_STAT_OFS;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            aw_addr      <= 8'h00;
            w_held       <= 1'b0;
            w_data       <= 32'h0;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
            ctrl         <= `FHPB_CTRL_RESET;
            irq_mask     <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'h0;
                case (aw_addr)
                    `FHPB_CTRL_OFS: begin
                        ctrl <= (ctrl & ~wmask) | (w_data & wmask & `FHPB_CTRL_WR_MASK);
                    end
                    `FHPB_IRQ_MASK_OFS: begin
                        if (w_strb[0]) begin
                            irq_mask <= w_data[3:0];
                        end
                    end
                    `FHPB_STAT_OFS, `FHPB_IRQ_STAT_OFS, `FHPB_SEQ_OFS: begin
                        s_axi_bresp <= 2'h0;
                    end
                    default: begin
                        s_axi_bresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read
    // ------------------------------------------------------------
    // reads never wait on the write side, so status polls stay quick
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= 2'h0;
            s_axi_rdata  <= 32'h0;
        end else if (ce) begin
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                case (s_axi_araddr)
                    `FHPB_CTRL_OFS:     s_axi_rdata <= ctrl;
                    `FHPB_STAT_OFS:     s_axi_rdata <= stat_word;
                    `FHPB_IRQ_STAT_OFS: s_axi_rdata <= {28'h0, irq_stat};
                    `FHPB_IRQ_MASK_OFS: s_axi_rdata <= {28'h0, irq_mask};
                    `FHPB_SEQ_OFS:      s_axi_rdata <= {16'h0, seq_count};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // hot mode
    // ------------------------------------------------------------
    // unused inputs count as on; no input assigned keeps mode off
    wire all_on = (use_mask != 2'h0) && ((contact_s | ~use_mask) == 2'h3);
    wire hot_ok = (policy != `FHPB_POL_DISABLE) && !lockout;
    wire next_hot = hot_ok && all_on && !(diag_state == DG_PULSE);
    assign hot_mode_out = hot;
    // flame supervision still runs elsewhere; only the advance is forced
    assign ignite_ok = start_req && (hot || flame_sensed);

    // ------------------------------------------------------------
    // purge decision
    // ------------------------------------------------------------
    // purge already underway is never cancelled
    wire decide = linked ? air_ok_point : heat_demand_point;
    wire may_skip = (policy == `FHPB_POL_NORMAL)
                    || (policy == `FHPB_POL_FIRST && first_done);
    wire skip_now = decide && !in_purge_phase && hot && may_skip;

    always @(posedge aclk) begin
        if (!aresetn) begin
            hot        <= 1'b0;
            skip_purge <= 1'b0;
            run_purge  <= 1'b0;
            first_done <= 1'b0;
            seq_count  <= 16'h0;
        end else if (ce) begin
            hot        <= next_hot;
            skip_purge <= skip_now;
            run_purge  <= decide && !skip_now;
            if (ctrl[`FHPB_CTRL_RESTART]) begin
                first_done <= 1'b0;
            end else if (decide) begin
                first_done <= 1'b1;
                seq_count  <= seq_count + 16'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // contact diagnosis and lockout
    // ------------------------------------------------------------
    wire disagree = hot_ok && (use_mask == 2'h3) && (contact_s[0] != contact_s[1]);
    wire stuck = (diag_state == DG_WAIT) && (diag_cnt >= DIAG_WAIT_CYC)
                 && ((contact_s & use_mask) != 2'h0);
    // count restarts on every agreement, so only a steady split trips
    wire lock_mis = disagree && (mis_cnt >= MISMATCH_CYC - 40'h1);
    wire lock_set = (lock_mis || stuck) && !lockout;

    always @(posedge aclk) begin
        if (!aresetn) begin
            mis_cnt    <= 40'h0;
            diag_cnt   <= 40'h0;
            diag_state <= DG_IDLE;
            diag_out   <= 2'h3;
            lockout    <= 1'b0;
        end else if (ce) begin
            if (disagree) begin
                mis_cnt <= mis_cnt + 40'h1;
            end else begin
                mis_cnt <= 40'h0;
            end
            if (lock_mis) begin
                lockout <= 1'b1;
            end
            if (stuck) begin
                lockout <= 1'b1;
            end
            if (ctrl[`FHPB_CTRL_RESTART]) begin
                lockout <= 1'b0;
            end
            case (diag_state)
                DG_IDLE: begin
                    diag_out <= 2'h3;
                    if (!hot) begin
                        diag_cnt <= 40'h0;
                    end else if (diag_cnt >= DIAG_PERIOD_CYC - 40'h1) begin
                        diag_cnt   <= 40'h0;
                        diag_out   <= 2'h0;
                        diag_state <= DG_PULSE;
                    end else begin
                        diag_cnt <= diag_cnt + 40'h1;
                    end
                end
                DG_PULSE: begin
                    diag_out <= 2'h0;
                    diag_cnt <= diag_cnt + 40'h1;
                    if (diag_cnt >= DIAG_PULSE_CYC - 40'h1) begin
                        diag_cnt   <= 40'h0;
                        diag_state <= DG_WAIT;
                    end
                end
                DG_WAIT: begin
                    diag_out <= 2'h0;
                    diag_cnt <= diag_cnt + 40'h1;
                    if ((contact_s & use_mask) == 2'h0 || stuck) begin
                        diag_cnt   <= 40'h0;
                        diag_out   <= 2'h3;
                        diag_state <= DG_IDLE;
                    end
                end
                default: begin
                    diag_state <= DG_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    // lockout event only on entry, not on every split cycle
    always @* begin
        irq_event                   = 4'h0;
        irq_event[`FHPB_EV_ENTER]   = next_hot & ~hot;
        irq_event[`FHPB_EV_EXIT]    = hot & ~next_hot;
        irq_event[`FHPB_EV_LOCKOUT] = lock_set;
        irq_event[`FHPB_EV_SKIP]    = skip_now;
    end

    // one sticky flag per event; set wins over the clearing read
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_irq_bit
            reg flag;
            always @(posedge aclk) begin
                if (!aresetn) begin
                    flag <= 1'b0;
                end else if (ce) begin
                    flag <= irq_event[gi] | (flag & ~rd_irq);
                end
            end
            assign irq_stat[gi] = flag;
        end
    endgenerate

    assign irq = |(irq_stat & irq_mask);
endmodule
`default_nettype wire

// file: tb/fhpb_partner.sv
// model of the two temperature controllers
// assumes the bench sets furnace heat and stuck faults
`timescale 1ns/1ps
`default_nettype none
module fhpb_partner (
    // clock
    input  wire logic       aclk,
    // diagnosis from the block, commands from the bench
    input  wire logic [1:0] diag_out,
    input  wire logic [1:0] hot_req,
    input  wire logic [1:0] stuck,
    // contacts
    output var  logic [1:0] hot_contact
);
    // healthy controller drops its contact while asked
    always @(posedge aclk) begin
        hot_contact <= hot_req & (diag_out | stuck);
    end
endmodule
`default_nettype wire

// file: tb/fhpb_top_asserts.sv
// port checker of the hot-mode purge bypass block
// assumes ce high and both contacts in use
`timescale 1ns/1ps
`default_nettype none
module fhpb_top_asserts #(
    parameter [39:0] MISMATCH_CYC = 40'd400
) (
    // clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // contacts and sequencer
    input wire logic [1:0] hot_contact,
    input wire logic       air_ok_point,
    input wire logic       heat_demand_point,
    input wire logic       in_purge_phase,
    input wire logic       start_req,
    input wire logic       flame_sensed,
    // answers
    input wire logic       skip_purge,
    input wire logic       run_purge,
    input wire logic       ignite_ok,
    input wire logic       lockout,
    input wire logic       hot_mode_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----
    // mismatch age
    // ----
    // saturates, so a long run cannot wrap it
    reg [39:0] mis_cnt;
    always @(posedge aclk) begin
        if (!aresetn || hot_contact[0] == hot_contact[1])
            mis_cnt <= 40'h0;
        else if (!(&mis_cnt))
            mis_cnt <= mis_cnt + 40'h1;
    end
    sequence s_decide; air_ok_point || heat_demand_point; endsequence
    property p_ignite; ignite_ok == (start_req && (hot_mode_out || flame_sensed)); endproperty
    a_ignite: assert property (p_ignite) else $error("ignite wrong");
    property p_enter; $rose(hot_mode_out) |-> $past(hot_contact, 3) == 2'b11; endproperty
    a_enter: assert property (p_enter) else $error("entry without contacts");
    property p_exit; (hot_contact != 2'b11) [*4] |-> !hot_mode_out; endproperty
    a_exit: assert property (p_exit) else $error("hot mode held");
    property p_cold; s_decide ##0 !hot_mode_out |=> !skip_purge; endproperty
    a_cold: assert property (p_cold) else $error("cold skip");
    property p_purge; s_decide ##0 in_purge_phase |=> !skip_purge; endproperty
    a_purge: assert property (p_purge) else $error("purge cut");
    property p_answer; s_decide |=> skip_purge ^ run_purge; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_cause; skip_purge || run_purge |-> $past(air_ok_point || heat_demand_point); endproperty
    a_cause: assert property (p_cause) else $error("answer without cause");
    property p_lock; lockout [*2] |-> !hot_mode_out; endproperty
    a_lock: assert property (p_lock) else $error("hot in lockout");
    property p_mismatch; mis_cnt > MISMATCH_CYC + 40'd4 |-> lockout; endproperty
    a_mismatch: assert property (p_mismatch) else $error("no lockout");
endmodule
bind fhpb_top fhpb_top_asserts #(.MISMATCH_CYC(MISMATCH_CYC)) fhpb_top_asserts_inst (.*);
`default_nettype wire

// file: tb/fhpb_top_test.sv
// bench of the hot-mode purge bypass block
// assumes the partner model stands in for both controllers
`timescale 1ns/1ps
`default_nettype none
`include "fhpb_defs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module fhpb_top_test;
    typedef struct packed {
        logic [1:0] pol;
        logic       lnk;
        logic [1:0] con;
        logic       purge;
        logic       rst;
        logic       skip;
    } fhpb_row_t;
    localparam logic [1:0] PD = `FHPB_POL_DISABLE;
    // ----
    // signals
    // ----
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, hot_contact, diag_out, resp;
    logic [1:0]  hot_req = 2'b00, stuck = 2'b00;
    logic        air_ok_point = 1'b0, heat_demand_point = 1'b0, in_purge_phase = 1'b0;
    logic        start_req = 1'b1, flame_sensed = 1'b0, exp_hot;
    logic        skip_purge, run_purge, ignite_ok, lockout, hot_mode_out, irq;
    int          err_total = 0, checked = 0, i;
    fhpb_row_t   r;
    // fields: policy, linked, contacts, purge phase, restart, skip expected
    fhpb_row_t   rows [8] = '{8'h18, 8'hb8, 8'hf9, 8'hd9, 8'hc8, 8'hfc, 8'h5a, 8'h59};

    always #2 aclk = ~aclk;
    // short counts keep the run brief
    fhpb_top #(.MISMATCH_CYC(40'd400), .DIAG_PERIOD_CYC(40'd3000), .DIAG_PULSE_CYC(40'd5),
        .DIAG_WAIT_CYC(40'd10)) fhpb_top_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .hot_contact(hot_contact), .diag_out(diag_out),
        .air_ok_point(air_ok_point), .heat_demand_point(heat_demand_point),
        .in_purge_phase(in_purge_phase), .start_req(start_req), .flame_sensed(flame_sensed),
        .skip_purge(skip_purge), .run_purge(run_purge), .ignite_ok(ignite_ok),
        .lockout(lockout), .hot_mode_out(hot_mode_out), .irq(irq));
    fhpb_partner fhpb_partner_inst (.aclk(aclk), .diag_out(diag_out), .hot_req(hot_req),
        .stuck(stuck), .hot_contact(hot_contact));
    // ----
    // bus tasks
    // ----
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
    endtask
    task automatic decide(input logic lnk);
        @(posedge aclk);
        air_ok_point <= lnk;
        heat_demand_point <= !lnk;
        @(posedge aclk);
        air_ok_point <= 1'b0;
        heat_demand_point <= 1'b0;
        // the answer stands for this one cycle only
        @(negedge aclk);
    endtask
    task automatic stop_test;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge aclk);
        err_total++;
        $display("[FAIL] %0t watchdog", $time);
        stop_test();
    end
    // ----
    // tests
    // ----
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 8; i++) begin
            r = rows[i];
            exp_hot = r.pol != PD && r.con == 2'b11;
            if (r.rst)
                wr(`FHPB_CTRL_OFS, 32'h38 | {29'h0, r.lnk, r.pol});
            wr(`FHPB_CTRL_OFS, 32'h18 | {29'h0, r.lnk, r.pol});
            @(posedge aclk);
            hot_req <= r.con;
            in_purge_phase <= r.purge;
            repeat (6) @(posedge aclk);
            @(negedge aclk);
            `CHK({hot_mode_out, ignite_ok, irq}, {exp_hot, exp_hot, 1'b0})
            decide(r.lnk);
            `CHK({skip_purge, run_purge}, {r.skip, !r.skip})
        end
        rd(`FHPB_SEQ_OFS);
        `CHK(rdat, 32'h8)
        $display("table done");
        @(posedge aclk);
        hot_req <= 2'b00;
        flame_sensed <= 1'b1;
        repeat (6) @(posedge aclk);
        @(negedge aclk);
        `CHK({hot_mode_out, ignite_ok}, 2'b01)
        wr(`FHPB_CTRL_OFS, 32'h1b);
        wr(`FHPB_IRQ_MASK_OFS, 32'h4);
        @(posedge aclk);
        hot_req <= 2'b11;
        flame_sensed <= 1'b0;
        // first pulse with healthy controllers, second with one stuck on
        for (i = 0; i < 2; i++) begin
            while (diag_out === 2'b11) @(posedge aclk);
            repeat (40) @(posedge aclk);
            @(negedge aclk);
            `CHK({lockout, hot_mode_out, irq}, i ? 3'b101 : 3'b010)
            @(posedge aclk);
            stuck <= 2'b01;
        end
        rd(`FHPB_IRQ_STAT_OFS);
        `CHK(rdat[2], 1'b1)
        rd(`FHPB_IRQ_STAT_OFS);
        `CHK({rdat[2], irq}, 2'b00)
        @(posedge aclk);
        stuck <= 2'b00;
        wr(`FHPB_CTRL_OFS, 32'h3b);
        wr(`FHPB_CTRL_OFS, 32'h1b);
        @(negedge aclk);
        `CHK(lockout, 1'b0)
        $display("diagnosis done");
        @(posedge aclk);
        hot_req <= 2'b10;
        repeat (380) @(posedge aclk);
        @(negedge aclk);
        `CHK(lockout, 1'b0)
        repeat (40) @(posedge aclk);
        @(negedge aclk);
        `CHK(lockout, 1'b1)
        $display("mismatch done");
        @(posedge aclk);
        hot_req <= 2'b11;
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        `CHK({lockout, hot_mode_out, diag_out, irq}, 5'b00110)
        rd(`FHPB_CTRL_OFS);
        `CHK(rdat, `FHPB_CTRL_RESET)
        wr(`FHPB_STAT_OFS, 32'hffff_ffff);
        `CHK(resp, 2'b00)
        rd(8'h40);
        `CHK({resp, rdat}, {2'b10, 32'h0})
        $display("reset and map done");
        stop_test();
    end
endmodule
`default_nettype wire
